/* logic/boot_mode_pkg.sv */
// boot mode loader constants: mode codes, addresses, defaults, timing
// assumes a 100 MHz system clock and synchronous active-high reset
package boot_mode_pkg;
   localparam int          SEL_W          = 4;
   localparam logic [3:0]  MODE_IDLE      = 4'h0;
   localparam logic [3:0]  MODE_PFLASH    = 4'h1;
   localparam logic [3:0]  MODE_AFIFO     = 4'h2;
   localparam logic [3:0]  MODE_SPI_MEM   = 4'h3;
   localparam logic [3:0]  MODE_SPI_HOST  = 4'h4;
   localparam logic [3:0]  MODE_TW_MEM    = 4'h5;
   localparam logic [3:0]  MODE_TW_HOST   = 4'h6;
   localparam logic [3:0]  MODE_UART_HOST = 4'h7;
   localparam logic [3:0]  MODE_SDRAM     = 4'hA;
   localparam logic [3:0]  MODE_OTP       = 4'hB;
   localparam logic [3:0]  MODE_NAND      = 4'hD;
   localparam logic [3:0]  MODE_HDMA16    = 4'hE;
   localparam logic [3:0]  MODE_HDMA8     = 4'hF;
   localparam logic [31:0] ADDR_PFLASH    = 32'h2000_0000;
   localparam logic [31:0] ADDR_AFIFO     = 32'h2030_0000;
   localparam logic [31:0] ADDR_SDRAM     = 32'h0000_0010;
   localparam logic [31:0] ADDR_ZERO      = 32'h0000_0000;
   localparam logic [3:0]  PF_SETUP       = 4'h4;
   localparam logic [4:0]  PF_ACCESS      = 5'h0F;
   localparam logic [3:0]  PF_HOLD        = 4'h3;
   localparam logic [15:0] SPI_BAUD_DEF   = 16'h0085;
   localparam logic [7:0]  SPI_ADDR_BYTE  = 8'h00;
   localparam logic [7:0]  TW_MEM_SLAVE   = 8'hA0;
   localparam logic [15:0] TW_MEM_START   = 16'h0000;
   localparam logic [7:0]  TW_PRESCALE    = 8'h0A;
   localparam logic [15:0] TW_TWO_WIRE_CLOCK_DIVIDER      = 16'h0811;
   localparam logic [7:0]  TW_HOST_BYTE   = 8'h5F;
   localparam logic [7:0]  UART_SYNC      = 8'h40;
   localparam logic [7:0]  UART_ACK0      = 8'hBF;
   localparam logic [7:0]  UART_ACK3      = 8'h00;
   localparam logic [15:0] NAND_CTL_DEF   = 16'h0033;
   localparam logic [2:0]  NAND_ADDR_CYC  = 3'h4;
   localparam logic [7:0]  NAND_CMD_RST   = 8'hFF;
   localparam logic [7:0]  NAND_CMD_RDLO  = 8'h00;
   localparam logic [7:0]  NAND_CMD_RDHI  = 8'h01;
   localparam logic [7:0]  NAND_CMD_SPARE = 8'h50;
   localparam int          NAND_PAGE_B    = 512;
   localparam int          NAND_PAGES     = 32;
   localparam int          NAND_SPARE_B   = 16;
   localparam int          CLK_MHZ        = 100;
   localparam int          PULSE_NS       = 20;   // dma request low time
   localparam int          PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int          BAUD_CNT_W     = 20;
endpackage

/* logic/boot_mode_loader.sv */
// boot mode loader: samples the select pins at reset, drives defaults, host wait,
// dma requests, autobaud and its four-byte reply through a two-entry buffer
// assumes all inputs synchronous to i_sys_clk; firmware feeds fetch strobes
// What this block does
// - sample four select pins at power-on and software reset, pick mode
// - codes 0000 to 0111: idle, flash, fifo, spi mem/host, twi mem/host, uart
// - codes 1010 sdram, 1011 otp, 1101 nand, 1110/1111 host dma; others reserved
// - idle code enters idle state and loads nothing
// - every mode starts with slowest interface settings unless overridden (otp override here only holds the slowest defaults)
// - host wait polarity from strap; ready drives the opposite level
// - host wait on port b pin eleven, or port h pin seven by option
// - parallel flash reads header at 0x20000000, setup 4, access 15, hold 3
// - async ready input stays disabled unless settings enable it
// - fifo mode reads 0x20300000, one low dma pulse per 16-bit word
// - spi memory select on port e, read command, 0x00 bytes, divider 0x85
// - two-wire memory: slave 0xA0, sequential reads from address 0x0000
// - two-wire memory prescale 0xA and divider 0x0811 by default
// - two-wire host addresses 0x5F, device acknowledges and accepts stream
// - uart host sends 0x40 8N1; device measures it for bit rate
// - reply 0xBF, divisor low, divisor high, 0x00 before boot stream
// - keep request-to-send deasserted until the reply is sent, clear-to-send disabled in uart boot
// - sdram mode warm boots from 0x00000010
// - nand enables chip enable and ready/busy, control 0x0033, block 0 byte 0
// - nand mode never toggles host wait, pin left undriven
// - small-page nand: four address cycles, 512-byte pages, 32 pages, 16 spare
// - small-page nand commands 0xFF, 0x00, 0x01, 0x50
`timescale 1ns/100ps
`default_nettype none
module boot_mode_loader
   import boot_mode_pkg::*;
(
   input  wire logic             i_sys_clk,         // system clock
   input  wire logic             i_srst,            // sync reset, high
   input  wire logic             i_por_or_swrst,    // high for a power-on or software reset
   input  wire logic [SEL_W-1:0] i_boot_select_pins,// mode straps
   input  wire logic             i_wait_strap,      // level of host wait pull resistor
   input  wire logic             i_alt_wait_pin_option, // otp: wait on port h pin seven
   input  wire logic             i_otp_override,    // otp holds current settings
   input  wire logic             i_otp_async_ready_input_en,     // otp enables async ready
   input  wire logic             i_ready_for_data,  // kernel ready for next data
   input  wire logic             i_boot_done,       // boot completed, release pins
   input  wire logic             i_word_fetch,      // kernel fetches one fifo word
   input  wire logic             i_async_receive_input, // uart receive pin
   input  wire logic             i_tx_ready,        // uart transmitter takes a byte
   output logic [3:0]            o_mode,            // latched mode code
   output logic                  o_idle,            // idle, nothing loaded
   output logic [31:0]           o_start_addr,      // first read address
   output logic [3:0]            o_setup_cyc,       // flash setup cycles
   output logic [4:0]            o_access_cyc,      // flash access cycles
   output logic [3:0]            o_hold_cyc,        // flash hold cycles
   output logic                  o_async_ready_input_en,         // async ready input enable
   output logic [15:0]           o_serial_bit_rate_divider, // spi divider
   output logic                  o_serial_memory_select_gpio, // spi memory select, low
   output logic [7:0]            o_tw_slave,        // two-wire slave byte
   output logic [7:0]            o_tw_prescale,     // two-wire prescale
   output logic [15:0]           o_two_wire_clock_divider, // two-wire divider
   output logic                  o_tw_slave_mode,   // acknowledge address 0x5F
   output logic                  o_dma_request_line_one, // fifo request, low pulse
   output logic                  o_port_b_pin_eleven_o,  // default wait pin value
   output logic                  o_port_b_pin_eleven_oe, // default wait pin enable
   output logic                  o_port_h_pin_seven_o,   // alternate wait pin value
   output logic                  o_port_h_pin_seven_oe,  // alternate wait pin enable
   output logic                  o_request_to_send_output, // rts, high = deasserted
   output logic                  o_cts_en,          // clear-to-send function enable
   output logic [15:0]           o_divisor,         // measured uart divisor
   output logic                  o_baud_locked,     // autobaud done
   output logic [7:0]            o_tx_data,         // reply byte
   output logic                  o_tx_valid,        // reply byte valid
   output logic                  o_nand_chip_enable_en,  // port j pin one as chip enable
   output logic                  o_nand_ready_busy_en,   // port j pin two as ready/busy
   output logic [15:0]           o_nand_controller_control, // control write value
   output logic [2:0]            o_nand_addr_cycles,// address cycles per read
   output logic [7:0]            o_nand_cmd_reset,  // reset command
   output logic [7:0]            o_nand_cmd_read_lo,// read lower half command
   output logic [7:0]            o_nand_cmd_read_hi,// read upper half command
   output logic [7:0]            o_nand_cmd_spare   // read spare command
);
   typedef enum logic [2:0] {AB_IDLE, AB_MEAS, AB_REPLY, AB_DONE} ab_state_t;

   // mode legality: reserved codes fall back to idle
   function automatic logic [3:0] legal_mode(input logic [3:0] m);
      if (m == 4'h8 || m == 4'h9 || m == 4'hC) begin
         legal_mode = MODE_IDLE;
      end else begin
         legal_mode = m;
      end
   endfunction

   logic [3:0]  mode_q, mode_d;
   logic        armed_q, armed_d;
   // mode capture on the clock edge after reset release
   always_comb begin
      mode_d  = mode_q;
      armed_d = armed_q;
      if (armed_q) begin
         mode_d  = legal_mode(i_boot_select_pins);
         armed_d = 1'b0;
      end else if (i_por_or_swrst) begin
         armed_d = 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         mode_q  <= MODE_IDLE;
         armed_q <= 1'b1;
      end else begin
         mode_q  <= mode_d;
         armed_q <= armed_d;
      end
   end

   // per-mode configuration outputs
   logic [31:0] addr_d;
   logic        nand_d, uart_d, twh_d, spim_d;
   always_comb begin
      nand_d = (mode_q == MODE_NAND);
      uart_d = (mode_q == MODE_UART_HOST);
      twh_d  = (mode_q == MODE_TW_HOST);
      spim_d = (mode_q == MODE_SPI_MEM);
      case (mode_q)
         MODE_PFLASH: addr_d = ADDR_PFLASH;
         MODE_AFIFO:  addr_d = ADDR_AFIFO;
         MODE_SDRAM:  addr_d = ADDR_SDRAM;
         default:     addr_d = ADDR_ZERO;    // nand block 0 byte 0
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_mode                      <= MODE_IDLE;
         o_idle                      <= 1'b1;
         o_start_addr                <= ADDR_ZERO;
         o_nand_chip_enable_en       <= 1'b0;
         o_nand_ready_busy_en        <= 1'b0;
         o_nand_controller_control   <= 16'h0000;
         o_tw_slave_mode             <= 1'b0;
         o_serial_memory_select_gpio <= 1'b1;
         o_cts_en                    <= 1'b0;
         o_async_ready_input_en                   <= 1'b0;
      end else begin
         o_mode                      <= mode_q;
         o_idle                      <= (mode_q == MODE_IDLE);
         o_start_addr                <= addr_d;
         o_nand_chip_enable_en       <= nand_d;
         o_nand_ready_busy_en        <= nand_d;
         o_nand_controller_control   <= nand_d ? NAND_CTL_DEF : 16'h0000;
         o_tw_slave_mode             <= twh_d;
         o_serial_memory_select_gpio <= ~(spim_d && !i_boot_done);
         o_cts_en                    <= 1'b0;
         o_async_ready_input_en                   <= (mode_q == MODE_PFLASH) && i_otp_async_ready_input_en;
      end
   end

   // slowest defaults; otp override only holds the current timing values
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || !i_otp_override) begin
         o_setup_cyc               <= PF_SETUP;
         o_access_cyc              <= PF_ACCESS;
         o_hold_cyc                <= PF_HOLD;
         o_serial_bit_rate_divider <= SPI_BAUD_DEF;
         o_tw_prescale             <= TW_PRESCALE;
         o_two_wire_clock_divider  <= TW_TWO_WIRE_CLOCK_DIVIDER;
      end else begin
         o_setup_cyc               <= o_setup_cyc;
         o_access_cyc              <= o_access_cyc;
         o_hold_cyc                <= o_hold_cyc;
         o_serial_bit_rate_divider <= o_serial_bit_rate_divider;
         o_tw_prescale             <= o_tw_prescale;
         o_two_wire_clock_divider  <= o_two_wire_clock_divider;
      end
   end

   // fixed protocol constants for two-wire and nand
   always_ff @(posedge i_sys_clk) begin
      o_tw_slave          <= (mode_q == MODE_TW_HOST) ? TW_HOST_BYTE : TW_MEM_SLAVE;
      o_nand_addr_cycles  <= NAND_ADDR_CYC;
      o_nand_cmd_reset    <= NAND_CMD_RST;
      o_nand_cmd_read_lo  <= NAND_CMD_RDLO;
      o_nand_cmd_read_hi  <= NAND_CMD_RDHI;
      o_nand_cmd_spare    <= NAND_CMD_SPARE;
   end

   // host wait: strap polarity, pin choice, released after boot, quiet in nand
   logic wait_lvl_d, drive_d;
   always_comb begin
      wait_lvl_d = i_ready_for_data ? ~i_wait_strap : i_wait_strap;
      drive_d    = !i_boot_done && !nand_d && !o_idle;
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_port_b_pin_eleven_o  <= 1'b0;
         o_port_b_pin_eleven_oe <= 1'b0;
         o_port_h_pin_seven_o   <= 1'b0;
         o_port_h_pin_seven_oe  <= 1'b0;
      end else begin
         o_port_b_pin_eleven_o  <= wait_lvl_d;
         o_port_b_pin_eleven_oe <= drive_d && !i_alt_wait_pin_option;
         o_port_h_pin_seven_o   <= wait_lvl_d;
         o_port_h_pin_seven_oe  <= drive_d && i_alt_wait_pin_option;
      end
   end

   // fifo dma request: one low pulse per fetched word
   logic [3:0] pulse_q, pulse_d;
   always_comb begin
      pulse_d = pulse_q;
      if (pulse_q != 4'h0) begin
         pulse_d = pulse_q - 4'h1;
      end else if (i_word_fetch && mode_q == MODE_AFIFO) begin
         pulse_d = 4'(PULSE_CYC);
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pulse_q                <= 4'h0;
         o_dma_request_line_one <= 1'b1;
      end else begin
         pulse_q                <= pulse_d;
         o_dma_request_line_one <= (pulse_d == 4'h0);
      end
   end

   // autobaud: measure 0x40 start bit plus six zero data bits = 7 bit times
   ab_state_t              ab_q, ab_d;
   logic [BAUD_CNT_W-1:0]  cnt_q, cnt_d;
   logic [15:0]            div_q, div_d;
   logic [1:0]             idx_q, idx_d;
   logic                   rx_q;
   logic [7:0]             in_data;
   logic                   in_valid, in_ready;
   always_comb begin
      ab_d     = ab_q;
      cnt_d    = cnt_q;
      div_d    = div_q;
      idx_d    = idx_q;
      in_valid = 1'b0;
      case (idx_q)
         2'd0:    in_data = UART_ACK0;
         2'd1:    in_data = div_q[7:0];
         2'd2:    in_data = div_q[15:8];
         default: in_data = UART_ACK3;
      endcase
      case (ab_q)
         AB_IDLE: begin
            if (uart_d && rx_q && !i_async_receive_input) begin
               ab_d  = AB_MEAS;
               cnt_d = '0;
            end
         end
         AB_MEAS: begin
            cnt_d = cnt_q + 1'b1;
            if (i_async_receive_input) begin
               // bit time = low span / 7, divisor = bit time / 16
               div_d = 16'(cnt_q / (7 * 16));
               idx_d = 2'd0;
               ab_d  = AB_REPLY;
            end
         end
         AB_REPLY: begin
            in_valid = 1'b1;
            if (in_ready) begin
               idx_d = idx_q + 2'd1;
               if (idx_q == 2'd3) begin
                  ab_d = AB_DONE;
               end
            end
         end
         AB_DONE: ab_d = AB_DONE;
         default: ab_d = AB_IDLE;
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ab_q  <= AB_IDLE;
         cnt_q <= '0;
         div_q <= 16'h0000;
         idx_q <= 2'd0;
         rx_q  <= 1'b1;
      end else begin
         ab_q  <= ab_d;
         cnt_q <= cnt_d;
         div_q <= div_d;
         idx_q <= idx_d;
         rx_q  <= i_async_receive_input;
      end
   end

   // two-entry reply buffer toward the transmitter
   logic [7:0] buf_q [2], buf_d [2];
   logic       rd_q, rd_d, wr_q, wr_d;
   logic [1:0] cnt2_q, cnt2_d;
   logic       push, pop;
   always_comb begin
      in_ready = (cnt2_q != 2'd2);
      push     = in_valid && in_ready;
      pop      = o_tx_valid && i_tx_ready;
      buf_d    = buf_q;
      wr_d     = wr_q;
      rd_d     = rd_q;
      if (push) begin
         buf_d[wr_q] = in_data;
         wr_d        = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      cnt2_d = cnt2_q + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt2_q   <= 2'd0;
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
      end else begin
         buf_q    <= buf_d;
         wr_q     <= wr_d;
         rd_q     <= rd_d;
         cnt2_q   <= cnt2_d;
         o_tx_valid <= (cnt2_d != 2'd0);
         o_tx_data  <= buf_d[rd_d];
      end
   end

   // uart status: rts held deasserted until reply sent
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_request_to_send_output <= 1'b1;
         o_divisor                <= 16'h0000;
         o_baud_locked            <= 1'b0;
      end else begin
         o_request_to_send_output <= !(ab_q == AB_DONE && cnt2_q == 2'd0);
         o_divisor                <= div_q;
         o_baud_locked            <= (ab_q == AB_REPLY) || (ab_q == AB_DONE);
      end
   end
endmodule
`default_nettype wire

/* dv/boot_mode_loader_chk.sv */
// checker for the boot mode loader: mode decode, fifo pulses, wait pins, reply
// assumes binding to the loader top, one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module boot_mode_loader_chk
   import boot_mode_pkg::*;
(
   input wire logic       i_sys_clk,                // clock
   input wire logic       i_srst,                   // reset
   input wire logic       i_word_fetch,             // fifo fetch
   input wire logic       i_wait_strap,             // wait strap
   input wire logic       i_ready_for_data,         // ready
   input wire logic       i_otp_async_ready_input_en,            // ready enable
   input wire logic       i_tx_ready,               // reply sink
   input wire logic [3:0] o_mode,                   // mode
   input wire logic       o_dma_request_line_one,   // fifo request
   input wire logic       o_port_b_pin_eleven_o,    // wait level
   input wire logic       o_port_b_pin_eleven_oe,   // wait enable
   input wire logic       o_port_h_pin_seven_oe,    // alt enable
   input wire logic       o_async_ready_input_en,                // ready input on
   input wire logic       o_request_to_send_output, // rts
   input wire logic       o_cts_en,                 // cts on
   input wire logic       o_tx_valid,               // reply valid
   input wire logic [7:0] o_tx_data                 // reply byte
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // fifo request: two cycles low, caused by a fetch in fifo mode
   chk_fifo_pulse_len: assert property ($fell(o_dma_request_line_one) |=>
      !o_dma_request_line_one ##1 o_dma_request_line_one) else $error("dma pulse length");
   chk_fifo_pulse_cause: assert property ($fell(o_dma_request_line_one) |->
      $past(i_word_fetch) && o_mode == MODE_AFIFO) else $error("dma pulse cause");
   chk_reserved_idle: assert property (!(o_mode inside {4'h8, 4'h9, 4'hC}))
      else $error("reserved code kept");
   // wait pin level follows strap and readiness, one pin at a time
   chk_wait_level: assert property (o_port_b_pin_eleven_oe |->
      o_port_b_pin_eleven_o == ($past(i_ready_for_data) ^ $past(i_wait_strap)))
      else $error("wait level");
   chk_wait_one_pin: assert property (!(o_port_b_pin_eleven_oe && o_port_h_pin_seven_oe))
      else $error("both wait pins driven");
   chk_nand_float: assert property (o_mode == MODE_NAND [*2] |->
      !o_port_b_pin_eleven_oe && !o_port_h_pin_seven_oe) else $error("wait driven in nand");
   chk_idle_float: assert property (o_mode == MODE_IDLE [*2] |->
      !o_port_b_pin_eleven_oe && !o_port_h_pin_seven_oe) else $error("wait driven in idle");
   chk_async_ready_input_off: assert property (!i_otp_async_ready_input_en [*2] |-> !o_async_ready_input_en)
      else $error("ready input enabled");
   chk_cts_off: assert property (!o_cts_en)
      else $error("cts enabled");
   chk_rts_hold: assert property (o_tx_valid |-> o_request_to_send_output)
      else $error("rts asserted during reply");
   chk_reply_hold: assert property (o_tx_valid && !i_tx_ready |=>
      o_tx_valid && $stable(o_tx_data)) else $error("reply byte dropped");
   // main scenarios
   cov_fifo: cover property ($fell(o_dma_request_line_one));
   cov_reply: cover property (o_tx_valid && i_tx_ready && o_tx_data == UART_ACK0);
   cov_stall: cover property (o_tx_valid && !i_tx_ready);
   cov_nand: cover property (o_mode == MODE_NAND);
endmodule
`default_nettype wire

/* dv/uart_host_model.sv */
// uart boot host: sends the sync character and sinks the four-byte reply
// assumes the bench calls send_sync after the device is in uart host mode
`timescale 1ns/100ps
`default_nettype none
module uart_host_model (
   input  wire logic i_clk,      // system clock
   input  wire logic i_slow,     // stall the reply sink at random
   output logic      o_rx,       // line into the device receiver
   output logic      o_tx_ready  // reply sink ready
);
   // line idles high between frames
   initial begin
      o_rx = 1'b1;
      o_tx_ready = 1'b0;
   end
   // sink readiness moves just after the falling edge
   always @(negedge i_clk) begin
      o_tx_ready <= i_slow ? (($urandom % 3) == 0) : 1'b1;
   end
   // sync 0x40 framed 8n1, lsb first
   task automatic send_sync(input int bit_cyc);
      logic [9:0] frame;
      frame = {1'b1, boot_mode_pkg::UART_SYNC, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rx = frame[i];
         repeat (bit_cyc) @(negedge i_clk);
      end
   endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the boot mode loader with a uart host partner
// assumes 100 MHz clock, inputs driven at the falling edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import boot_mode_pkg::*;
   logic        i_sys_clk = 0, i_srst = 1, i_por_or_swrst = 0, i_wait_strap = 0;
   logic        i_alt_wait_pin_option = 0, i_otp_override = 0, i_otp_async_ready_input_en = 0;
   logic        i_ready_for_data = 0, i_boot_done = 0, i_word_fetch = 0, slow = 0;
   logic [3:0]  i_boot_select_pins = MODE_SDRAM, o_mode, o_setup_cyc, o_hold_cyc, exp;
   logic [4:0]  o_access_cyc;
   logic [2:0]  o_nand_addr_cycles;
   logic [7:0]  o_tw_slave, o_tw_prescale, o_tx_data, o_nand_cmd_reset, o_nand_cmd_read_lo;
   logic [7:0]  o_nand_cmd_read_hi, o_nand_cmd_spare;
   logic [15:0] o_serial_bit_rate_divider, o_two_wire_clock_divider, o_divisor, d;
   logic [15:0] o_nand_controller_control;
   logic [31:0] o_start_addr;
   logic        o_idle, o_async_ready_input_en, o_serial_memory_select_gpio, o_tw_slave_mode, rx, tx_rdy;
   logic        o_dma_request_line_one, o_port_b_pin_eleven_o, o_port_b_pin_eleven_oe;
   logic        o_port_h_pin_seven_o, o_port_h_pin_seven_oe, o_request_to_send_output;
   logic        o_cts_en, o_baud_locked, o_tx_valid, o_nand_chip_enable_en, o_nand_ready_busy_en;
   logic        woe;
   logic [7:0]  exp_q[$];
   int          errors = 0, comparisons = 0, pulses = 0, n;
   // 100 MHz clock
   always #5 i_sys_clk = ~i_sys_clk;
   boot_mode_loader u_dut (.i_sys_clk, .i_srst, .i_por_or_swrst, .i_boot_select_pins,
      .i_wait_strap, .i_alt_wait_pin_option, .i_otp_override, .i_otp_async_ready_input_en, .i_ready_for_data,
      .i_boot_done, .i_word_fetch, .i_async_receive_input(rx), .i_tx_ready(tx_rdy), .o_mode,
      .o_idle, .o_start_addr, .o_setup_cyc, .o_access_cyc, .o_hold_cyc, .o_async_ready_input_en,
      .o_serial_bit_rate_divider, .o_serial_memory_select_gpio, .o_tw_slave, .o_tw_prescale,
      .o_two_wire_clock_divider, .o_tw_slave_mode, .o_dma_request_line_one,
      .o_port_b_pin_eleven_o, .o_port_b_pin_eleven_oe, .o_port_h_pin_seven_o,
      .o_port_h_pin_seven_oe, .o_request_to_send_output, .o_cts_en, .o_divisor, .o_baud_locked,
      .o_tx_data, .o_tx_valid, .o_nand_chip_enable_en, .o_nand_ready_busy_en,
      .o_nand_controller_control, .o_nand_addr_cycles, .o_nand_cmd_reset, .o_nand_cmd_read_lo,
      .o_nand_cmd_read_hi, .o_nand_cmd_spare);
   uart_host_model u_host (.i_clk(i_sys_clk), .i_slow(slow), .o_rx(rx), .o_tx_ready(tx_rdy));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic report_and_stop;
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge i_sys_clk);
   endtask
   task automatic hard_reset(input logic [3:0] code);
      i_boot_select_pins = code;
      i_srst = 1'b1;
      tick(2);
      i_srst = 1'b0;
      tick(4);
   endtask
   task automatic select_mode(input logic [3:0] code);
      i_boot_select_pins = code;
      i_por_or_swrst = 1'b1;
      tick(1);
      i_por_or_swrst = 1'b0;
      tick(4);
   endtask
   // reply monitor: each accepted byte against the oldest note
   always @(posedge i_sys_clk) begin
      if (!i_srst && o_tx_valid && tx_rdy) begin
         if (exp_q.size() == 0) check(1, 0);
         else check(o_tx_data, exp_q.pop_front());
      end
   end
   // count fifo request pulses
   always @(negedge o_dma_request_line_one) pulses++;
   initial begin
      void'($urandom(67801));
      hard_reset(MODE_SDRAM);
      check(o_mode, MODE_SDRAM);
      // sweep all codes through a software re-arm
      for (int c = 0; c < 16; c++) begin
         i_wait_strap = $urandom;
         i_ready_for_data = $urandom;
         i_alt_wait_pin_option = $urandom;
         i_otp_async_ready_input_en = $urandom;
         i_otp_override = $urandom;
         select_mode(c[3:0]);
         exp = (c inside {8, 9, 12}) ? 4'h0 : c[3:0];
         check(o_mode, exp);
         check(o_idle, exp == MODE_IDLE);
         check({o_setup_cyc, o_access_cyc, o_hold_cyc}, {PF_SETUP, PF_ACCESS, PF_HOLD});
         woe = !(exp inside {MODE_IDLE, MODE_NAND});
         check({o_port_b_pin_eleven_oe, o_port_h_pin_seven_oe},
               woe ? (i_alt_wait_pin_option ? 2'b01 : 2'b10) : 2'b00);
         if (woe) check(i_alt_wait_pin_option ? o_port_h_pin_seven_o : o_port_b_pin_eleven_o,
                        i_wait_strap ^ i_ready_for_data);
         case (exp)
            MODE_PFLASH: check(o_start_addr, ADDR_PFLASH);
            MODE_AFIFO: check(o_start_addr, ADDR_AFIFO);
            MODE_SDRAM: check(o_start_addr, ADDR_SDRAM);
            MODE_SPI_MEM: check({o_serial_memory_select_gpio, o_serial_bit_rate_divider},
                                {1'b0, SPI_BAUD_DEF});
            MODE_TW_MEM: check({o_tw_slave, o_tw_prescale, o_two_wire_clock_divider},
                               {TW_MEM_SLAVE, TW_PRESCALE, TW_TWO_WIRE_CLOCK_DIVIDER});
            MODE_TW_HOST: check({o_tw_slave_mode, o_tw_slave}, {1'b1, TW_HOST_BYTE});
            MODE_UART_HOST: check({o_request_to_send_output, o_cts_en}, 2'b10);
            MODE_NAND: begin
               check({o_nand_chip_enable_en, o_nand_ready_busy_en, o_nand_controller_control},
                     {2'b11, NAND_CTL_DEF});
               check(o_nand_addr_cycles, NAND_ADDR_CYC);
               check({o_nand_cmd_reset, o_nand_cmd_read_lo, o_nand_cmd_read_hi, o_nand_cmd_spare},
                     32'hFF00_0150);
            end
            default: ;
         endcase
      end
      // boot done frees the wait pin
      i_boot_done = 1'b1;
      tick(2);
      check({o_port_b_pin_eleven_oe, o_port_h_pin_seven_oe}, 2'b00);
      i_boot_done = 1'b0;
      // fifo fetches, each followed by one refused fetch during the pulse
      select_mode(MODE_AFIFO);
      pulses = 0;
      n = 2 + $urandom % 4;
      for (int k = 0; k < n; k++) begin
         i_word_fetch = 1'b1;
         tick(1);
         i_word_fetch = 1'b0;
         tick(1);
         i_word_fetch = 1'b1;
         tick(1);
         i_word_fetch = 1'b0;
         tick(5);
      end
      check(pulses, n);
      // autobaud with a prompt sink, then after a reset with a stalling sink
      for (int s = 0; s < 2; s++) begin
         hard_reset(MODE_UART_HOST);
         slow = s[0];
         d = 16'(1 + $urandom % 4);
         exp_q = {UART_ACK0, d[7:0], d[15:8], UART_ACK3};
         u_host.send_sync(16 * int'(d) + 1);
         for (int t = 0; t < 300 && exp_q.size() > 0; t++) tick(1);
         if (exp_q.size() != 0) begin
            check(exp_q.size(), 0);
            report_and_stop();
         end
         check({o_baud_locked, o_divisor}, {1'b1, d});
      end
      report_and_stop();
   end
endmodule
bind boot_mode_loader boot_mode_loader_chk u_chk (.i_sys_clk, .i_srst, .i_word_fetch,
   .i_wait_strap, .i_ready_for_data, .i_otp_async_ready_input_en, .i_tx_ready, .o_mode,
   .o_dma_request_line_one, .o_port_b_pin_eleven_o, .o_port_b_pin_eleven_oe,
   .o_port_h_pin_seven_oe, .o_async_ready_input_en, .o_request_to_send_output, .o_cts_en, .o_tx_valid,
   .o_tx_data);
`default_nettype wire
